/* src/uss_pkg.sv */
/*
 * constants of the synchronous slave serial port: register offsets,
 * bit positions, reset values and character lengths.
 * assumes nothing of its surroundings.
 */
package uss_pkg;
   // ***********************************
   // register offsets on the plain port
   // ***********************************
   localparam int unsigned AW = 3;
   localparam logic [2:0] OFS_RX_STAT = 3'h0;
   localparam logic [2:0] OFS_TX_STAT = 3'h1;
   localparam logic [2:0] OFS_BAUD    = 3'h2;
   localparam logic [2:0] OFS_TX_DATA = 3'h3;
   localparam logic [2:0] OFS_RX_DATA = 3'h4;
   localparam logic [2:0] OFS_INT_EN  = 3'h5;
   localparam logic [2:0] OFS_INT_FLG = 3'h6;
   localparam logic [2:0] OFS_ALT_PIN = 3'h7;
   // receive_status_control bits
   localparam int unsigned B_PORT_EN   = 7;
   localparam int unsigned B_RX_NINE   = 6;
   localparam int unsigned B_SINGLE_RX = 5;
   localparam int unsigned B_CONT_RX   = 4;
   localparam int unsigned B_ADEN      = 3;
   localparam int unsigned B_OVERRUN   = 1;
   localparam int unsigned B_RX_BIT9   = 0;
   // transmit_status_control bits
   localparam int unsigned B_CLK_MST     = 7;
   localparam int unsigned B_TX_NINE     = 6;
   localparam int unsigned B_TX_EN       = 5;
   localparam int unsigned B_SYNC        = 4;
   localparam int unsigned B_SNDB        = 3;
   localparam int unsigned B_BRGH        = 2;
   localparam int unsigned B_SHIFT_EMPTY = 1;
   localparam int unsigned B_TX_BIT9     = 0;
   // baud_control bits
   localparam int unsigned B_RIDL   = 6;
   localparam int unsigned B_CK_POL = 4;
   localparam int unsigned B_B16    = 3;
   localparam int unsigned B_WUE    = 1;
   localparam int unsigned B_ABD    = 0;
   // interrupt enable / flag bits, alternate pin bits
   localparam int unsigned B_PERIPH_IE = 6;
   localparam int unsigned B_RCI       = 5;
   localparam int unsigned B_TXI       = 4;
   localparam int unsigned B_ADT       = 7;
   localparam int unsigned B_ACK       = 2;
   // reset values and character lengths
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [3:0] LEN_8    = 4'h8;
   localparam logic [3:0] LEN_9    = 4'h9;
   localparam logic [1:0] FIFO_DEP = 2'h2;
endpackage

/* src/uss_sync_slave.sv */
/*
 * synchronous slave serial port: register file, pin synchronisers,
 * receive shifter with two-entry receive buffer, transmit shifter
 * with one-entry transmit buffer, and wake request.
 * assumes a software register port on mclk and an external master
 * that drives the shift clock far slower than mclk.
 */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps

// Summary of operation
// - slave reception works like master reception except sleep and enables
// - reception needs continuous receive enable set; clearing it idles the receiver
// - single receive enable is ignored in slave mode
// - with continuous enable set before sleep, characters arrive on external clock
// - a complete shifted word moves into the receive data buffer
// - with receive interrupt enable, a received word wakes the processor
// - receive complete flag sets at end of character; interrupt needs enable
// - in 9-bit mode read the ninth bit before the low byte
// - overrun clears only by clearing continuous enable or port enable
// - only synchronous slave mode keeps working during sleep
// - transmit and receive shifters move only on external clock edges
// - reading receive data unloads characters and clears the complete flag
// - a fully clocked-in word during sleep sets the complete flag
// - after wake the processor continues; interrupts vector if enabled
// - writing transmit data fills shifter and buffer, clears ready flag
// - in slave transmit, clock edges drive bits onto the data pin
// - when shifter empties, the buffered byte moves in and ready sets
// - then the buffer takes a new character, clearing ready again
// - clock and data pins can move to alternate locations
// - receive buffer holds two; a third sets overrun and blocks reception
// - continuous receive enable clear means transmit, else receive
module uss_sync_slave
   import uss_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // register port
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [7:0]    reg_rdata,
   // pins, two locations each
   input  wire logic [1:0]    ck_pin_in,
   input  wire logic [1:0]    dt_pin_in,
   output logic      [1:0]    dt_pin_out,
   output logic      [1:0]    dt_pin_oe,
   // status towards the processor
   output logic               receive_complete_flag,
   output logic               transmit_ready_flag,
   output logic               wake_req
);

   // ***********************************
   // declarations
   // ***********************************
   logic       port_en_q, rx_nine_q, single_rx_q, cont_rx_q, aden_q;
   logic       clk_mst_q, tx_nine_q, tx_en_q, sync_q, sndb_q, brgh_q, tx_bit9_q;
   logic       ck_pol_q, b16_q, wue_q, abd_q;
   logic       periph_ie_q, rx_ie_q, tx_ie_q, alt_dt_q, alt_ck_q;
   logic [3:0] sync1_q, sync2_q;
   logic       ck_prev_q;
   logic       ck_s, dt_s, ck_rise, ck_fall, edge_s;
   logic       slave_on, rx_mode, tx_mode;
   logic [8:0] rx_shift_q;
   logic [3:0] rx_cnt_q;
   logic [8:0] rx_shift_d;
   logic [3:0] rx_len, tx_len;
   logic       rx_done;
   logic [8:0] rx_word;
   logic [8:0] fifo_q [0:1];
   logic       wptr_q, rptr_q;
   logic [1:0] fcnt_q;
   logic       push, pop, ovr_set;
   logic       overrun_q;
   logic [8:0] txbuf_q, tx_shift_q;
   logic       buf_full_q, tx_shift_full_q;
   logic [3:0] tx_cnt_q;
   logic       wr_tx, tx_last;
   logic [8:0] tx_word;
   logic [7:0] rdata_q;
   logic       wake_q;

   // ***********************************
   // pin synchronisers and edge finding
   // ***********************************
   // two flops for every pin; the pins belong to the master's clock
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {dt_pin_in, ck_pin_in};
         sync2_q <= sync1_q;
      end
   end

   // location select after the synchroniser, never on the first flop
   assign ck_s = alt_ck_q ? sync2_q[1] : sync2_q[0];
   assign dt_s = alt_dt_q ? sync2_q[3] : sync2_q[2];

   // previous clock level for edge detection
   always_ff @(posedge mclk) begin
      if (rst) begin
         ck_prev_q <= 1'b0;
      end else begin
         ck_prev_q <= ck_s;
      end
   end

   assign ck_rise = ck_s & ~ck_prev_q;
   assign ck_fall = ~ck_s & ck_prev_q;
   // every shift step happens only on a master clock edge
   assign edge_s  = ck_pol_q ? ck_fall : ck_rise;

   // ***********************************
   // mode decoding
   // ***********************************
   // only external-clock slave mode shifts; it needs no system timing,
   // so it keeps running while the processor sleeps
   assign slave_on = port_en_q & sync_q & ~clk_mst_q;
   // single receive enable plays no part here
   assign rx_mode  = slave_on & cont_rx_q;
   assign tx_mode  = slave_on & ~cont_rx_q & tx_en_q;
   assign rx_len   = rx_nine_q ? LEN_9 : LEN_8;
   assign tx_len   = tx_nine_q ? LEN_9 : LEN_8;

   // ***********************************
   // register writes
   // ***********************************
   // control bits; every software write except transmit data lives here
   always_ff @(posedge mclk) begin
      if (rst) begin
         {port_en_q, rx_nine_q, single_rx_q, cont_rx_q, aden_q} <= 5'h00;
         {clk_mst_q, tx_nine_q, tx_en_q, sync_q} <= 4'h0;
         {sndb_q, brgh_q, tx_bit9_q} <= 3'h0;
         {ck_pol_q, b16_q, wue_q, abd_q} <= 4'h0;
         {periph_ie_q, rx_ie_q, tx_ie_q} <= 3'h0;
         {alt_dt_q, alt_ck_q} <= 2'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            OFS_RX_STAT: begin
               port_en_q   <= reg_wdata[B_PORT_EN];
               rx_nine_q   <= reg_wdata[B_RX_NINE];
               single_rx_q <= reg_wdata[B_SINGLE_RX];
               cont_rx_q   <= reg_wdata[B_CONT_RX];
               aden_q <= reg_wdata[B_ADEN];
            end
            OFS_TX_STAT: begin
               clk_mst_q <= reg_wdata[B_CLK_MST];
               tx_nine_q <= reg_wdata[B_TX_NINE];
               tx_en_q   <= reg_wdata[B_TX_EN];
               sync_q <= reg_wdata[B_SYNC];
               sndb_q <= reg_wdata[B_SNDB];
               brgh_q <= reg_wdata[B_BRGH];
               tx_bit9_q <= reg_wdata[B_TX_BIT9];
            end
            OFS_BAUD: begin
               ck_pol_q <= reg_wdata[B_CK_POL];
               b16_q  <= reg_wdata[B_B16];
               wue_q  <= reg_wdata[B_WUE];
               abd_q  <= reg_wdata[B_ABD];
            end
            OFS_INT_EN: begin
               periph_ie_q <= reg_wdata[B_PERIPH_IE];
               rx_ie_q     <= reg_wdata[B_RCI];
               tx_ie_q     <= reg_wdata[B_TXI];
            end
            OFS_ALT_PIN: begin
               alt_dt_q <= reg_wdata[B_ADT];
               alt_ck_q <= reg_wdata[B_ACK];
            end
            default: begin
               port_en_q <= port_en_q;
            end
         endcase
      end
   end

   // ***********************************
   // receive shifter
   // ***********************************
   // lsb first: bits enter at the top and walk down
   assign rx_shift_d = {dt_s, rx_shift_q[8:1]};
   assign rx_done    = edge_s & rx_mode & ~overrun_q
                    & (rx_cnt_q == rx_len - 4'h1);
   // an 8-bit word ends up in the upper eight places
   assign rx_word = rx_nine_q ? rx_shift_d : {1'b0, rx_shift_d[8:1]};

   // bit counter restarts whenever reception is off or overrun blocks it
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_shift_q <= 9'h000;
         rx_cnt_q   <= 4'h0;
      end else if (!rx_mode || overrun_q) begin
         rx_cnt_q <= 4'h0;
      end else if (edge_s) begin
         rx_shift_q <= rx_shift_d;
         rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
      end
   end

   // ***********************************
   // receive buffer, two characters
   // ***********************************
   assign pop     = reg_rd & (reg_addr == OFS_RX_DATA) & (fcnt_q != 2'h0);
   assign push    = rx_done & (fcnt_q != FIFO_DEP);
   assign ovr_set = rx_done & (fcnt_q == FIFO_DEP);

   // storage; a full buffer keeps its data when a third word completes
   always_ff @(posedge mclk) begin
      if (rst) begin
         fifo_q[0] <= 9'h000;
         fifo_q[1] <= 9'h000;
      end else if (push) begin
         fifo_q[wptr_q] <= rx_word;
      end
   end

   // pointers and fill count; port enable clear empties the buffer
   always_ff @(posedge mclk) begin
      if (rst || !port_en_q) begin
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         fcnt_q <= 2'h0;
      end else begin
         if (push) begin
            wptr_q <= ~wptr_q;
         end
         if (pop) begin
            rptr_q <= ~rptr_q;
         end
         case ({push, pop})
            2'b10:   fcnt_q <= fcnt_q + 2'h1;
            2'b01:   fcnt_q <= fcnt_q - 2'h1;
            default: fcnt_q <= fcnt_q;
         endcase
      end
   end

   // overrun flag; only the two enables clear it, reads do not
   always_ff @(posedge mclk) begin
      if (rst) begin
         overrun_q <= 1'b0;
      end else if (ovr_set) begin
         overrun_q <= 1'b1;
      end else if (!cont_rx_q || !port_en_q) begin
         overrun_q <= 1'b0;
      end
   end

   // flag follows the buffer, so a word landing as the last one is
   // read still leaves the flag set
   assign receive_complete_flag = (fcnt_q != 2'h0);

   // ***********************************
   // transmit buffer and shifter
   // ***********************************
   assign wr_tx   = reg_wr & (reg_addr == OFS_TX_DATA);
   assign tx_word = {tx_bit9_q, reg_wdata};
   assign tx_last = edge_s & tx_mode & tx_shift_full_q
                    & (tx_cnt_q == tx_len - 4'h1);

   // the shifter refills from the buffer when its last bit has gone;
   // a write lands in the shifter if it is free, else in the buffer
   always_ff @(posedge mclk) begin
      if (rst || !port_en_q) begin
         txbuf_q         <= 9'h000;
         tx_shift_q      <= 9'h000;
         buf_full_q      <= 1'b0;
         tx_shift_full_q <= 1'b0;
         tx_cnt_q        <= 4'h0;
      end else if (!tx_shift_full_q || tx_last) begin
         tx_cnt_q <= 4'h0;
         if (buf_full_q) begin
            tx_shift_q      <= txbuf_q;
            tx_shift_full_q <= 1'b1;
            buf_full_q      <= wr_tx;
            if (wr_tx) begin
               txbuf_q <= tx_word;
            end
         end else if (wr_tx) begin
            tx_shift_q      <= tx_word;
            tx_shift_full_q <= 1'b1;
         end else begin
            tx_shift_full_q <= 1'b0;
         end
      end else begin
         if (edge_s && tx_mode) begin
            tx_shift_q <= {1'b0, tx_shift_q[8:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
         end
         if (wr_tx) begin
            txbuf_q    <= tx_word;
            buf_full_q <= 1'b1;
         end
      end
   end

   // ready means the buffer can take a character
   assign transmit_ready_flag = ~buf_full_q;

   // ***********************************
   // data pin drive, per location
   // ***********************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_loc
         // the unselected location is never driven
         assign dt_pin_out[gi] = tx_shift_q[0];
         assign dt_pin_oe[gi]  = tx_mode & (alt_dt_q == gi[0]);
      end
   endgenerate

   // ***********************************
   // wake request
   // ***********************************
   // the processor vectors on its own; this only wakes it
   always_ff @(posedge mclk) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= (receive_complete_flag & rx_ie_q)
                 | (transmit_ready_flag & tx_ie_q & periph_ie_q);
      end
   end

   assign wake_req = wake_q;

   // ***********************************
   // register reads
   // ***********************************
   // ninth bit shows the head entry so it can be read before the byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q <= REG_RST;
      end else if (reg_rd) begin
         rdata_q <= REG_RST;
         case (reg_addr)
            OFS_RX_STAT: begin
               rdata_q[B_PORT_EN]   <= port_en_q;
               rdata_q[B_RX_NINE]   <= rx_nine_q;
               rdata_q[B_SINGLE_RX] <= single_rx_q;
               rdata_q[B_CONT_RX]   <= cont_rx_q;
               rdata_q[B_ADEN]      <= aden_q;
               rdata_q[B_OVERRUN]   <= overrun_q;
               rdata_q[B_RX_BIT9]   <= fifo_q[rptr_q][8];
            end
            OFS_TX_STAT: begin
               rdata_q[B_CLK_MST] <= clk_mst_q;
               rdata_q[B_TX_NINE] <= tx_nine_q;
               rdata_q[B_TX_EN]   <= tx_en_q;
               rdata_q[B_SYNC] <= sync_q;
               rdata_q[B_SNDB] <= sndb_q;
               rdata_q[B_BRGH] <= brgh_q;
               rdata_q[B_SHIFT_EMPTY] <= ~tx_shift_full_q;
               rdata_q[B_TX_BIT9]     <= tx_bit9_q;
            end
            OFS_BAUD: begin
               rdata_q[B_RIDL] <= (rx_cnt_q == 4'h0);
               rdata_q[B_CK_POL] <= ck_pol_q;
               rdata_q[B_B16]  <= b16_q;
               rdata_q[B_WUE]  <= wue_q;
               rdata_q[B_ABD]  <= abd_q;
            end
            OFS_RX_DATA: begin
               rdata_q <= fifo_q[rptr_q][7:0];
            end
            OFS_INT_EN: begin
               rdata_q[B_PERIPH_IE] <= periph_ie_q;
               rdata_q[B_RCI]       <= rx_ie_q;
               rdata_q[B_TXI]       <= tx_ie_q;
            end
            OFS_INT_FLG: begin
               rdata_q[B_RCI] <= receive_complete_flag;
               rdata_q[B_TXI] <= transmit_ready_flag;
            end
            OFS_ALT_PIN: begin
               rdata_q[B_ADT] <= alt_dt_q;
               rdata_q[B_ACK] <= alt_ck_q;
            end
            default: begin
               rdata_q <= REG_RST;
            end
         endcase
      end
   end

   assign reg_rdata = rdata_q;

endmodule // uss_sync_slave

/* bench/uss_sync_slave_asserts.sv */
/*
 * checker of the serial port, watching only the top module's ports.
 * assumes one mclk domain with synchronous active high reset.
 */
`timescale 1ns/100ps
module uss_chk
   import uss_pkg::*;
(
   // clock and reset
   input wire logic          mclk,
   input wire logic          rst,
   // register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   // pins and status
   input wire logic [1:0]    ck_pin_in,
   input wire logic [1:0]    dt_pin_in,
   input wire logic [1:0]    dt_pin_out,
   input wire logic [1:0]    dt_pin_oe,
   input wire logic          receive_complete_flag,
   input wire logic          transmit_ready_flag,
   input wire logic          wake_req
);
   // ***********************************
   // helpers and assertions
   // ***********************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [1:0] ck_last_q;
   logic [3:0] ck_age_q;
   // age of the last shift clock move, saturating so it never wraps
   always_ff @(posedge mclk) begin
      ck_last_q <= ck_pin_in;
      if (rst || ck_pin_in != ck_last_q)
         ck_age_q <= 4'h0;
      else if (ck_age_q != 4'hf)
         ck_age_q <= ck_age_q + 4'h1;
   end
   chk_reset_state_ok: assert property ($past(rst) |-> !receive_complete_flag && transmit_ready_flag
      && !wake_req && dt_pin_oe == 2'b00 && reg_rdata == 8'h00) else $error("bad state after reset");
   chk_oe_one_loc: assert property ($onehot0(dt_pin_oe))
      else $error("data pin driven at both locations");
   chk_out_both_same: assert property (dt_pin_out[0] == dt_pin_out[1])
      else $error("data out differs between locations");
   chk_wake_has_cause: assert property (wake_req |-> $past(receive_complete_flag || transmit_ready_flag))
      else $error("wake without a pending flag");
   chk_txdata_reads_zero: assert property (reg_rd && reg_addr == OFS_TX_DATA |=> reg_rdata == 8'h00)
      else $error("write-only register read back nonzero");
   chk_flag_reg_match: assert property (reg_rd && reg_addr == OFS_INT_FLG |=>
      reg_rdata[B_RCI] == $past(receive_complete_flag) && reg_rdata[B_TXI] == $past(transmit_ready_flag))
      else $error("flag register disagrees with flag ports");
   chk_rc_fall_cause: assert property ($fell(receive_complete_flag) |-> $past(reg_rd && reg_addr == OFS_RX_DATA)
      || $past(reg_wr && reg_addr == OFS_RX_STAT && !reg_wdata[B_PORT_EN], 2)
      || $past(reg_wr && reg_addr == OFS_RX_STAT && !reg_wdata[B_PORT_EN]))
      else $error("receive flag dropped alone");
   chk_tx_fall_cause: assert property ($fell(transmit_ready_flag) |-> $past(reg_wr && reg_addr == OFS_TX_DATA)
      || $past(reg_wr && reg_addr == OFS_TX_DATA, 2)) else $error("ready flag dropped without a data write");
   chk_rx_needs_clock: assert property ($rose(receive_complete_flag) |-> ck_age_q < 4'h8)
      else $error("word completed without a shift clock edge");
   chk_oe_after_write: assert property ($changed(dt_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("pin direction changed without a register write");
   // main scenarios reached
   cov_rx_word: cover property ($rose(receive_complete_flag));
   cov_tx_refill: cover property ($rose(transmit_ready_flag));
   cov_wake: cover property ($rose(wake_req));
endmodule // uss_chk

/* bench/uss_master_model.sv */
/*
 * behavioural external master of the synchronous link: makes the shift
 * clock and drives or samples the data line.
 * assumes the bench resolves the data line from both parties.
 */
`timescale 1ns/100ps
module uss_master_model (
   // link towards the slave
   output logic      ck,
   output logic      dt,
   input  wire logic dt_line
);
   // ***********************************
   // frame engine
   // ***********************************
   initial begin
      ck = 1'b0;
      dt = 1'b1;
   end
   // n bits lsb first, 80 ns halves; clock stands still between frames
   task automatic xfer(input logic [8:0] w, input int n, input logic pol, output logic [8:0] got);
      got = 9'h000;
      ck = pol;
      for (int i = 0; i < n; i++) begin
         dt = w[i];
         #80;
         got[i] = dt_line; // slave bit settled well before the active edge
         ck = ~pol;
         #80;
         ck = pol;
      end
      dt = ~dt; // released line shows the inverse of the last bit
   endtask
endmodule // uss_master_model

/* bench/uss_sync_slave_test.sv */
/*
 * self-checking bench of the synchronous slave serial port.
 * assumes package, design, checker and master model compiled first.
 */
`timescale 1ns/100ps
module uss_sync_slave_test
   import uss_pkg::*;
;
   // ***********************************
   // harness
   // ***********************************
   logic          mclk, rst, reg_wr, reg_rd, loc, pol, m_ck, m_dt;
   logic [AW-1:0] reg_addr;
   logic [7:0]    reg_wdata, reg_rdata;
   logic [1:0]    dt_pin_out, dt_pin_oe;
   logic          rc_flag, tx_flag, wake;
   logic [8:0]    g;
   int            n_mismatch = 0;
   int            checked = 0;
   // data line: slave wins while it drives its selected location
   wire  logic    dt_line = dt_pin_oe[loc] ? dt_pin_out[loc] : m_dt;

   uss_sync_slave dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ck_pin_in(loc ? {m_ck, 1'b0} : {1'b0, m_ck}), .dt_pin_in({2{dt_line}}),
      .dt_pin_out(dt_pin_out), .dt_pin_oe(dt_pin_oe), .receive_complete_flag(rc_flag),
      .transmit_ready_flag(tx_flag), .wake_req(wake));
   uss_master_model m_u (.ck(m_ck), .dt(m_dt), .dt_line(dt_line));

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read, then judge the masked data just after the edge that captures it
   task automatic rdc(input logic [AW-1:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      cmp8(reg_rdata & m, exp);
   endtask
   task automatic send(input logic [8:0] w, input int n);
      #2; // pins move between mclk edges, results are read off the edge
      m_u.xfer(w, n, pol, g);
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_reset;
      rdc(OFS_RX_STAT, 8'hff, 8'h00);
      rdc(OFS_INT_FLG, 8'h30, 8'h10);
      rdc(OFS_TX_STAT, 8'h02, 8'h02);
   endtask
   task automatic t_rx;
      wr(OFS_TX_STAT, 8'h10); // pins are digital here, no analog select
      wr(OFS_INT_EN, 8'h20);
      wr(OFS_RX_STAT, 8'ha0);
      send(9'h0a5, 8);
      cmp8({7'h0, rc_flag}, 8'h00);
      wr(OFS_RX_STAT, 8'hb0);
      send(9'h0a5, 8);
      cmp8({6'h0, rc_flag, wake}, 8'h03);
      rdc(OFS_INT_FLG, 8'h20, 8'h20);
      rdc(OFS_RX_DATA, 8'hff, 8'ha5);
      cmp8({7'h0, rc_flag}, 8'h00);
   endtask
   task automatic t_overrun;
      wr(OFS_INT_EN, 8'h00);
      send(9'h011, 8);
      send(9'h022, 8);
      cmp8({6'h0, rc_flag, wake}, 8'h02);
      send(9'h033, 8);
      rdc(OFS_RX_STAT, 8'h02, 8'h02);
      rdc(OFS_RX_DATA, 8'hff, 8'h11);
      send(9'h044, 8);
      rdc(OFS_RX_DATA, 8'hff, 8'h22);
      cmp8({7'h0, rc_flag}, 8'h00);
      rdc(OFS_RX_STAT, 8'h02, 8'h02);
      wr(OFS_RX_STAT, 8'h80);
      rdc(OFS_RX_STAT, 8'h02, 8'h00);
      wr(OFS_RX_STAT, 8'h90);
      send(9'h055, 8);
      wr(OFS_RX_STAT, 8'h10);
      settle;
      cmp8({7'h0, rc_flag}, 8'h00);
      wr(OFS_RX_STAT, 8'h90);
   endtask
   task automatic t_rx_nine;
      wr(OFS_RX_STAT, 8'hd0);
      send(9'h13c, 9);
      rdc(OFS_RX_STAT, 8'h01, 8'h01);
      rdc(OFS_RX_DATA, 8'hff, 8'h3c);
   endtask
   // park the clock at the new idle level with the port off
   task automatic t_pol;
      wr(OFS_RX_STAT, 8'h00);
      pol = 1'b1;
      send(9'h000, 0);
      wr(OFS_BAUD, 8'h10);
      wr(OFS_RX_STAT, 8'h90);
      send(9'h0c6, 8);
      rdc(OFS_RX_DATA, 8'hff, 8'hc6);
      wr(OFS_RX_STAT, 8'h00);
      pol = 1'b0;
      send(9'h000, 0);
      wr(OFS_BAUD, 8'h00);
      wr(OFS_RX_STAT, 8'h90);
   endtask
   task automatic t_alt;
      wr(OFS_ALT_PIN, 8'h84);
      loc <= 1'b1;
      send(9'h05a, 8);
      rdc(OFS_RX_DATA, 8'hff, 8'h5a);
   endtask
   task automatic t_tx;
      wr(OFS_RX_STAT, 8'h80);
      wr(OFS_TX_STAT, 8'h30);
      wr(OFS_INT_EN, 8'h50);
      settle;
      cmp8({6'h0, dt_pin_oe}, 8'h02);
      wr(OFS_TX_DATA, 8'h96);
      wr(OFS_TX_DATA, 8'h3c);
      settle;
      cmp8({6'h0, tx_flag, wake}, 8'h00);
      send(9'h000, 8);
      cmp8(g[7:0], 8'h96);
      cmp8({6'h0, tx_flag, wake}, 8'h03);
      wr(OFS_TX_DATA, 8'ha5);
      settle;
      cmp8({7'h0, tx_flag}, 8'h00);
      send(9'h000, 8);
      cmp8(g[7:0], 8'h3c);
      send(9'h000, 8);
      cmp8(g[7:0], 8'ha5);
      // nine-bit character: ninth bit taken at the data write, sent last
      wr(OFS_TX_STAT, 8'h71);
      wr(OFS_TX_DATA, 8'h5a);
      send(9'h000, 9);
      cmp8(g[7:0], 8'h5a);
      cmp8({7'h0, g[8]}, 8'h01);
   endtask

   task automatic summarize;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // free running 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = 8'h00;
      loc = 1'b0;
      pol = 1'b0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_rx;
      t_overrun;
      t_rx_nine;
      t_pol;
      t_alt;
      t_tx;
      summarize;
   end
   // watchdog: fourteen frames need some 19 us, so 200 us means a hang
   initial begin
      #200000;
      n_mismatch++;
      summarize;
   end
endmodule // uss_sync_slave_test

bind uss_sync_slave uss_chk chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck_pin_in(ck_pin_in), .dt_pin_in(dt_pin_in),
   .dt_pin_out(dt_pin_out), .dt_pin_oe(dt_pin_oe), .receive_complete_flag(receive_complete_flag),
   .transmit_ready_flag(transmit_ready_flag), .wake_req(wake_req));
